// file: bench/dlip_core_checker.sv
`timescale 1ns/1ps
module dlip_core_checker
   import dlip_pkg::*;
#(
   parameter int MEM_AW = 4 // storage depth, not needed by the checks
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // inputs of the device
   input wire dlip_cmd_t cmd_i,
   input wire logic write_strobe_clk_i,
   input wire logic write_mask_i,
   input wire logic [DLIP_DQ_W-1:0] dq_i,
   // outputs of the device
   input wire logic [DLIP_DQ_W-1:0] dq_o,
   input wire logic dq_oe_o,
   input wire logic [1:0] read_strobe_clock_o,
   input wire logic [1:0] read_strobe_clock_n_o,
   input wire logic read_valid_flag_o,
   input wire logic init_done_o,
   input wire logic [DLIP_MODE_W-1:0] mode_o,
   input wire logic [DLIP_BANKS-1:0] banks_refreshed_o
);
   //--------------------------------------------------------------
   // pin decode and properties
   //--------------------------------------------------------------
   wire ms = !cmd_i.select_n && {cmd_i.write_cmd_n, cmd_i.refresh_cmd_n} == DLIP_CMD_MODE_SET; // mode-set
   wire rf = !cmd_i.select_n && {cmd_i.write_cmd_n, cmd_i.refresh_cmd_n} == DLIP_CMD_REFRESH; // refresh
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_grp; ms [*3]; endsequence
   sequence s_burst; read_strobe_clock_o[0] ##1 read_valid_flag_o && !read_strobe_clock_o[0] ##1 !read_valid_flag_o; endsequence
   property p_comp; read_strobe_clock_n_o == ~read_strobe_clock_o && read_strobe_clock_o[1] == read_strobe_clock_o[0]; endproperty
   a_comp: assert property (p_comp) else $error("read clocks not complementary");
   property p_run; !rst_i |=> read_strobe_clock_o[0] != $past(read_strobe_clock_o[0]); endproperty
   a_run: assert property (p_run) else $error("read clock stopped");
   property p_burst; $rose(read_valid_flag_o) |-> s_burst; endproperty
   a_burst: assert property (p_burst) else $error("read beats misaligned");
   property p_oe; dq_oe_o == read_valid_flag_o; endproperty
   a_oe: assert property (p_oe) else $error("drive and valid differ");
   property p_init; !init_done_o |-> !read_valid_flag_o; endproperty
   a_init: assert property (p_init) else $error("read data before init");
   property p_mode; ms |-> ##2 mode_o == $past(cmd_i.addr[DLIP_MODE_W-1:0], 2); endproperty
   a_mode: assert property (p_mode) else $error("mode not loaded");
   property p_nop; cmd_i.select_n |-> ##2 mode_o == $past(mode_o); endproperty
   a_nop: assert property (p_nop) else $error("deselected command acted");
   property p_grp; s_grp |-> ##2 init_done_o && banks_refreshed_o == '0; endproperty
   a_grp: assert property (p_grp) else $error("group reset missing");
   property p_ref; rf |-> ##2 banks_refreshed_o[$past(cmd_i.bank, 2)]; endproperty
   a_ref: assert property (p_ref) else $error("refresh not recorded");
endmodule : dlip_core_checker
bind dlip_core dlip_core_checker #(.MEM_AW(MEM_AW)) dlip_core_checker_i (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .write_strobe_clk_i(write_strobe_clk_i),
   .write_mask_i(write_mask_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
   .read_strobe_clock_o(read_strobe_clock_o), .read_strobe_clock_n_o(read_strobe_clock_n_o),
   .read_valid_flag_o(read_valid_flag_o), .init_done_o(init_done_o), .mode_o(mode_o),
   .banks_refreshed_o(banks_refreshed_o));

// file: bench/dlip_host_model.sv
`timescale 1ns/1ps
module dlip_host_model
   import dlip_pkg::*;
(
   // link side toward the device
   output logic wclk_o,
   output logic mask_o,
   output wire logic [DLIP_DQ_W-1:0] dq_wire_o,
   // device drive on the shared data wire
   input wire logic [DLIP_DQ_W-1:0] dev_dq_i,
   input wire logic dev_oe_i,
   // beats from the bench
   input wire dlip_wpair_t pair_i,
   input wire logic act_i
);
   //--------------------------------------------------------------
   // write strobe clock and write beats
   //--------------------------------------------------------------
   logic [DLIP_DQ_W-1:0] host_dq = '0; // host's own drive, one clock for both lanes
   initial mask_o = 1'b0;
   // free-running, never paused between writes; odd start keeps its edges off the command clock
   initial begin
      wclk_o = 1'b0;
      #3.3;
      forever #6 wclk_o = ~wclk_o;
   end
   // rise beat set up before the rising edge; idle data lines toggle so stale data never looks valid
   always @(negedge wclk_o) begin
      host_dq <= act_i ? pair_i.rise : ~host_dq;
      mask_o <= act_i & pair_i.mask_rise;
   end
   // fall beat set up before the falling edge
   always @(posedge wclk_o) begin
      host_dq <= act_i ? pair_i.fall : ~host_dq;
      mask_o <= act_i & pair_i.mask_fall;
   end
   // the device wins the wire only while it drives
   assign dq_wire_o = dev_oe_i ? dev_dq_i : host_dq;
endmodule : dlip_host_model

// file: bench/tb_dlip_core.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_dlip_core
   import dlip_pkg::*;
();
   //--------------------------------------------------------------
   // stimulus, expectations and closing
   //--------------------------------------------------------------
   logic sys_clk_i = 1'b0; // command clock
   logic rst_i = 1'b1; // held for 16 cycles
   dlip_cmd_t cmd_i = '1; // deselected at start
   dlip_wpair_t pair = '0; // beats the host sends
   logic act = 1'b0; // host is writing
   logic wclk, mask, dq_oe_o, read_valid_flag_o, init_done_o;
   wire [DLIP_DQ_W-1:0] dq_wire; // resolved data wire
   logic [DLIP_DQ_W-1:0] dq_o;
   logic [1:0] rclk, rclk_n;
   logic [DLIP_MODE_W-1:0] mode_o;
   logic [DLIP_BANKS-1:0] banks;
   logic [DLIP_DQ_W-1:0] mem [16]; // expected storage
   logic [31:0] seed = 32'h81a8; // fixed seed
   int n_errors = 0;
   int checks_done = 0;
   localparam int CLK_NS = 100; // command clock period in ns
   localparam int IDLE_CYC = 200_000 / CLK_NS; // 200 us of power-up NOPs
   localparam int MRSC_NS = 400; // mode-set recovery, plain default
   localparam int RC_NS = 400; // row cycle time, plain default
   localparam int MRSC_CYC = (MRSC_NS + CLK_NS - 1) / CLK_NS; // recovery in whole cycles
   localparam int RC_CYC = (RC_NS + CLK_NS - 1) / CLK_NS; // row cycle in whole cycles
   localparam int REF_NOPS = 1024; // NOPs spread over the bank refreshes
   localparam int REF_GAP = REF_NOPS / DLIP_BANKS > RC_CYC ? REF_NOPS / DLIP_BANKS : RC_CYC; // NOPs per refresh
   always #50 sys_clk_i = ~sys_clk_i;
   dlip_core #(.MEM_AW(4)) dlip_core_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_i(cmd_i),
      .write_strobe_clk_i(wclk), .write_mask_i(mask), .dq_i(dq_wire), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
      .read_strobe_clock_o(rclk), .read_strobe_clock_n_o(rclk_n), .read_valid_flag_o(read_valid_flag_o),
      .init_done_o(init_done_o), .mode_o(mode_o), .banks_refreshed_o(banks));
   dlip_host_model dlip_host_model_i (.wclk_o(wclk), .mask_o(mask), .dq_wire_o(dq_wire), .dev_dq_i(dq_o),
      .dev_oe_i(dq_oe_o), .pair_i(pair), .act_i(act));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // a masked beat leaves the old word in place
   function automatic logic [DLIP_DQ_W-1:0] stored(logic m, logic [DLIP_DQ_W-1:0] old, logic [DLIP_DQ_W-1:0] b);
      return m ? old : b;
   endfunction : stored
   task automatic wrap_up();
      if (n_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   // one command cycle, driven on the falling edge
   task automatic send(logic sel, logic [1:0] e, logic [2:0] b, logic [20:0] a);
      @(negedge sys_clk_i);
      cmd_i = {sel, e, b, a};
   endtask : send
   // deselected cycles carry random encodings that must be ignored
   task automatic nop(int n);
      repeat (n) send(1'b1, 2'(rnd()), 3'(rnd()), 21'(rnd()));
   endtask : nop
   // data held from the command until the store is done
   task automatic wr(logic [3:0] a, logic [1:0] m);
      pair = {rnd(), 4'(rnd()), rnd(), 4'(rnd()), m};
      act = 1'b1;
      send(1'b0, DLIP_CMD_WRITE, 3'(rnd()), {17'(rnd()), a});
      nop(8);
      mem[a] = stored(m[1], mem[a], pair.rise);
      mem[a + 4'h1] = stored(m[0], mem[a + 4'h1], pair.fall);
   endtask : wr
   task automatic rd(logic [3:0] a);
      int k;
      send(1'b0, DLIP_CMD_READ, 3'(rnd()), {17'(rnd()), a});
      for (k = 0; k < 8 && read_valid_flag_o !== 1'b1; k++) nop(1);
      if (k == 8) begin
         n_errors++;
         wrap_up();
      end
      `CHK({rclk, dq_o}, {2'h3, mem[a]})
      nop(1);
      `CHK({read_valid_flag_o, rclk, dq_o}, {1'b1, 2'h0, mem[a + 4'h1]})
      nop(1);
      `CHK(dq_oe_o, 1'b0)
   endtask : rd
   initial begin
      int i;
      logic [20:0] md;
      logic [2:0] off;
      repeat (16) @(negedge sys_clk_i);
      `CHK({init_done_o, mode_o, banks, rclk_n}, {1'b0, 18'h0, 8'h0, 2'h3})
      rst_i = 1'b0;
      nop(IDLE_CYC);
      send(1'b0, DLIP_CMD_READ, 3'h0, 21'h0);
      nop(4);
      `CHK(dq_oe_o, 1'b0)
      repeat (2) send(1'b0, DLIP_CMD_MODE_SET, 3'h0, 21'h0);
      nop(3);
      `CHK(init_done_o, 1'b0)
      md = 21'(rnd());
      repeat (2) send(1'b0, DLIP_CMD_MODE_SET, 3'h0, 21'h0);
      send(1'b0, DLIP_CMD_MODE_SET, 3'(rnd()), md);
      nop(MRSC_CYC);
      `CHK({init_done_o, mode_o}, {1'b1, md[17:0]})
      off = 3'(rnd());
      for (i = 0; i < 8; i++) begin
         send(1'b0, DLIP_CMD_REFRESH, 3'(i) ^ off, 21'(rnd()));
         nop(REF_GAP);
      end
      `CHK({banks, mode_o}, {8'hff, md[17:0]})
      for (i = 0; i < 16; i += 2) wr(4'(i), 2'h0);
      for (i = 0; i < 12; i++) wr(4'(rnd()), 2'(rnd()));
      act = 1'b0;
      for (i = 0; i < 16; i++) rd(4'(i));
      repeat (3) send(1'b0, DLIP_CMD_MODE_SET, 3'h0, 21'h0);
      nop(3);
      `CHK(banks, 8'h0)
      wrap_up();
   end
endmodule : tb_dlip_core

// file: logic/dlip_core.sv
`timescale 1ns/1ps
module dlip_core
   import dlip_pkg::*;
#(
   parameter int MEM_AW = 4              // beats of storage, 2**MEM_AW
) (
   // command clock domain
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // command pins
   input wire dlip_cmd_t cmd_i,
   // write strobe clock (link domain), both lanes driven in phase
   input wire logic write_strobe_clk_i,
   input wire logic write_mask_i,
   // data bus, split into three signals
   input wire logic [DLIP_DQ_W-1:0] dq_i,
   output logic [DLIP_DQ_W-1:0] dq_o,
   output logic dq_oe_o,
   // read side outputs
   output logic [1:0] read_strobe_clock_o,
   output logic [1:0] read_strobe_clock_n_o,
   output logic read_valid_flag_o,
   // status
   output logic init_done_o,
   output logic [DLIP_MODE_W-1:0] mode_o,
   output logic [DLIP_BANKS-1:0] banks_refreshed_o
);
   //--------------------------------------------------------------
   // command capture and decode
   //--------------------------------------------------------------
   dlip_cmd_t cmd_q;                     // registered command pins
   logic cmd_valid;                      // a command is selected this cycle
   logic [1:0] cmd_code;                 // decoded command
   logic [1:0] mrs_cnt;                  // consecutive mode-set count
   logic group_reset;                    // internal logic reset pulse

   // all command lines registered together on the rising edge
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cmd_q <= '{select_n: 1'b1, write_cmd_n: 1'b1, refresh_cmd_n: 1'b1, default: '0};
      end else begin
         cmd_q <= cmd_i;
      end
   end

   // select high acts as a NOP; work already under way goes on
   assign cmd_valid = ~cmd_q.select_n;
   assign cmd_code = {cmd_q.write_cmd_n, cmd_q.refresh_cmd_n};

   // count back-to-back mode-sets; any other cycle breaks the run
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         mrs_cnt <= '0;
      end else if (cmd_valid && cmd_code == DLIP_CMD_MODE_SET) begin
         if (mrs_cnt != DLIP_MRS_CNT_MAX) begin
            mrs_cnt <= mrs_cnt + 2'h1;
         end
      end else begin
         mrs_cnt <= '0;
      end
   end

   // third consecutive mode-set clears internal state; later ones in the run do too
   assign group_reset = cmd_valid && cmd_code == DLIP_CMD_MODE_SET
                        && mrs_cnt >= 2'(DLIP_MRS_GROUP - 1);

   // init done once a full group has been seen
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         init_done_o <= 1'b0;
      end else if (group_reset) begin
         init_done_o <= 1'b1;
      end
   end

   // every mode-set, dummy or not, loads the settings; the last one wins
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         mode_o <= '0;
      end else if (cmd_valid && cmd_code == DLIP_CMD_MODE_SET) begin
         mode_o <= cmd_q.addr[DLIP_MODE_W-1:0];
      end
   end

   // refresh bookkeeping per bank, restarted by the group reset
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || group_reset) begin
         banks_refreshed_o <= '0;
      end else if (cmd_valid && cmd_code == DLIP_CMD_REFRESH) begin
         banks_refreshed_o[cmd_q.bank] <= 1'b1;
      end
   end

   //--------------------------------------------------------------
   // storage
   //--------------------------------------------------------------
   logic [DLIP_DQ_W-1:0] mem [2**MEM_AW];  // beat storage, flip-flops
   logic [MEM_AW-1:0] wr_addr;             // burst start of pending write
   logic wr_pending;                       // waiting for a write pair
   logic [MEM_AW-1:0] rd_addr;             // burst start of pending read
   logic rd_pending;                       // waiting to launch a read
   logic rd_beat;                          // second beat of a read burst

   //--------------------------------------------------------------
   // write pair capture (link domain)
   //--------------------------------------------------------------
   logic arm_s1;                         // pending level, first stage
   logic arm_s2;                         // pending level, synchronised
   logic lrst_s1;                        // reset in the link domain, first stage
   logic lrst_s2;                        // reset in the link domain, synchronised
   logic taken;                          // pair already sent for this write
   logic req_tgl;                        // toggles when a pair is ready
   logic [DLIP_DQ_W-1:0] rise_q;         // rising edge beat
   logic mask_rise_q;                    // rising edge mask
   logic [DLIP_DQ_W-1:0] fall_q;         // falling edge beat
   logic mask_fall_q;                    // falling edge mask
   dlip_wpair_t pair_q;                  // held stable while req crosses

   // rising edge sample of every lane; lane split only matters electrically
   always_ff @(posedge write_strobe_clk_i) begin
      rise_q <= dq_i;
      mask_rise_q <= write_mask_i;
   end

   // falling edge sample
   always_ff @(negedge write_strobe_clk_i) begin
      fall_q <= dq_i;
      mask_fall_q <= write_mask_i;
   end

   // bring the pending level over; this clock runs without pause
   always_ff @(posedge write_strobe_clk_i) begin
      arm_s1 <= wr_pending;
      arm_s2 <= arm_s1;
   end

   // reset crosses into the link domain; the write clock must run while reset is held
   always_ff @(posedge write_strobe_clk_i) begin
      lrst_s1 <= rst_i;
      lrst_s2 <= lrst_s1;
   end

   // pair the previous rise with the fall that followed it, once per write
   always_ff @(posedge write_strobe_clk_i) begin
      if (lrst_s2) begin
         // a known toggle level, else the command side never sees a pair arrive
         taken <= 1'b0;
         req_tgl <= 1'b0;
      end else if (!arm_s2) begin
         taken <= 1'b0;
      end else if (!taken) begin
         pair_q <= '{rise: rise_q, fall: fall_q, mask_rise: mask_rise_q, mask_fall: mask_fall_q};
         req_tgl <= ~req_tgl;
         taken <= 1'b1;
      end
   end

   //--------------------------------------------------------------
   // write completion (command domain)
   //--------------------------------------------------------------
   logic req_s1;                         // toggle, first stage
   logic req_s2;                         // toggle, synchronised
   logic req_s3;                         // previous synchronised value
   logic pair_arrived;                   // one-cycle pulse
   logic new_write;                      // write command accepted

   always_ff @(posedge sys_clk_i) begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
   end

   assign pair_arrived = req_s2 ^ req_s3;
   assign new_write = cmd_valid && cmd_code == DLIP_CMD_WRITE && init_done_o;

   // pair_q is stable: it only changes after pending falls and rises again
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || group_reset) begin
         wr_pending <= 1'b0;
      end else if (pair_arrived && wr_pending) begin
         wr_pending <= 1'b0;
      end else if (new_write && !wr_pending) begin
         wr_pending <= 1'b1;
         wr_addr <= cmd_q.addr[MEM_AW-1:0];
      end
   end

   // store the two beats unless their mask sample was high
   always_ff @(posedge sys_clk_i) begin
      if (pair_arrived && wr_pending) begin
         if (!pair_q.mask_rise) begin
            mem[wr_addr] <= pair_q.rise;
         end
         if (!pair_q.mask_fall) begin
            mem[wr_addr + MEM_AW'(1)] <= pair_q.fall;
         end
      end
   end

   //--------------------------------------------------------------
   // read launch
   //--------------------------------------------------------------
   logic rd_clk;                         // read clock level, free running

   // read clock toggles every cycle, so each beat sits on one of its edges
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rd_clk <= 1'b0;
      end else begin
         rd_clk <= ~rd_clk;
      end
   end

   assign read_strobe_clock_o = {2{rd_clk}};
   assign read_strobe_clock_n_o = {2{~rd_clk}};

   // accept one read at a time; waits for the clock to sit low
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || group_reset) begin
         rd_pending <= 1'b0;
      end else if (rd_pending && !rd_clk && !rd_beat) begin
         rd_pending <= 1'b0;
      end else if (cmd_valid && cmd_code == DLIP_CMD_READ && init_done_o && !rd_pending) begin
         rd_pending <= 1'b1;
         rd_addr <= cmd_q.addr[MEM_AW-1:0];
      end
   end

   // first beat with the rising read clock edge, second with the falling one
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || group_reset) begin
         rd_beat <= 1'b0;
         dq_o <= '0;
         dq_oe_o <= 1'b0;
         read_valid_flag_o <= 1'b0;
      end else if (rd_pending && !rd_clk && !rd_beat) begin
         rd_beat <= 1'b1;
         dq_o <= mem[rd_addr];
         dq_oe_o <= 1'b1;
         read_valid_flag_o <= 1'b1;
      end else if (rd_beat) begin
         rd_beat <= 1'b0;
         dq_o <= mem[rd_addr + MEM_AW'(1)];
         read_valid_flag_o <= 1'b1;
      end else begin
         dq_oe_o <= 1'b0;
         read_valid_flag_o <= 1'b0;
      end
   end
endmodule : dlip_core

// file: logic/dlip_pkg.sv
//--------------------------------------------------------------
// dlip package: constants and carriers
//--------------------------------------------------------------
package dlip_pkg;
   //--------------------------------------------------------------
   // bus widths and lane split
   //--------------------------------------------------------------
   localparam int DLIP_DQ_W = 36;        // data bus width
   localparam int DLIP_LANE_W = 18;      // one write/read clock lane
   localparam int DLIP_ADDR_W = 21;      // address inputs
   localparam int DLIP_BANK_W = 3;       // bank address inputs
   localparam int DLIP_MODE_W = 18;      // mode settings taken from address
   localparam int DLIP_BANKS = 8;        // internal banks
   localparam int DLIP_MRS_GROUP = 3;    // consecutive mode-sets that reset logic
   localparam logic [1:0] DLIP_MRS_CNT_MAX = 2'h3;

   //--------------------------------------------------------------
   // command encodings on {write_cmd_n, refresh_cmd_n}, select low
   //--------------------------------------------------------------
   localparam logic [1:0] DLIP_CMD_MODE_SET = 2'h0;
   localparam logic [1:0] DLIP_CMD_WRITE = 2'h1;
   localparam logic [1:0] DLIP_CMD_REFRESH = 2'h2;
   localparam logic [1:0] DLIP_CMD_READ = 2'h3;

   // command pins sampled together on the command clock
   typedef struct packed {
      logic select_n;
      logic write_cmd_n;
      logic refresh_cmd_n;
      logic [DLIP_BANK_W-1:0] bank;
      logic [DLIP_ADDR_W-1:0] addr;
   } dlip_cmd_t;

   // one write clock cycle: two beats plus their mask samples
   typedef struct packed {
      logic [DLIP_DQ_W-1:0] rise;
      logic [DLIP_DQ_W-1:0] fall;
      logic mask_rise;
      logic mask_fall;
   } dlip_wpair_t;
endpackage : dlip_pkg
